// File: twe_event_ctrl.v
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "twe_regs.vh"

// What this block does
// - Suspended flag after final byte; traffic halts
// - Flag at start of final receive byte
// - Flag at start of final transmit byte
// - Stopped event routed to chosen enabled channel
// - Other six events routed the same way
// - Final tx byte link triggers receive start
// - Final tx byte link triggers suspend
// - Final tx byte link triggers stop
// - Final rx byte link triggers transmit start
// - Final rx byte link triggers suspend
// - Final rx byte link triggers stop
// - One enable bit per event gates interrupt
// - Set-enable writes ones, reads current enables
// - Set-enable covers all seven events alike
// - Clear-enable writes ones off, reads enables
module twe_event_ctrl #(
  parameter AW = 12,
  parameter CH_W = 4,
  parameter NCH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register port
  input wire [AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Event pulses from the transfer engine
  input wire evt_stopped,
  input wire evt_error,
  input wire evt_suspended,
  input wire evt_rx_begun,
  input wire evt_tx_begun,
  input wire evt_final_rx_byte,
  input wire evt_final_tx_byte,
  // Task pulses from subscribed channels
  input wire sub_begin_rx,
  input wire sub_begin_tx,
  input wire sub_stop,
  input wire sub_suspend,
  input wire sub_resume,
  // Task pulses to the transfer engine
  output reg begin_receive_task,
  output reg begin_transmit_task,
  output reg stop_task,
  output reg suspend_task,
  output reg resume_task,
  // Status
  output reg traffic_halted,
  output reg irq,
  // Event channel requests
  output reg [NCH-1:0] chan_pulse
);

  localparam NEV = 7;

  // Event index order used throughout
  localparam EV_STOPPED = 0;
  localparam EV_ERROR = 1;
  localparam EV_SUSP = 2;
  localparam EV_RXB = 3;
  localparam EV_TXB = 4;
  localparam EV_FRX = 5;
  localparam EV_FTX = 6;

  // Event vector to enable-register layout
  function [31:0] ev_to_word;
    input [NEV-1:0] v;
    begin
      ev_to_word = `TWE_ZERO_RST;
      ev_to_word[`TWE_IE_STOPPED_BIT] = v[EV_STOPPED];
      ev_to_word[`TWE_IE_ERROR_BIT] = v[EV_ERROR];
      ev_to_word[`TWE_IE_SUSPENDED_BIT] = v[EV_SUSP];
      ev_to_word[`TWE_IE_RX_BEGUN_BIT] = v[EV_RXB];
      ev_to_word[`TWE_IE_TX_BEGUN_BIT] = v[EV_TXB];
      ev_to_word[`TWE_IE_FINAL_RX_BIT] = v[EV_FRX];
      ev_to_word[`TWE_IE_FINAL_TX_BIT] = v[EV_FTX];
    end
  endfunction

  // Enable-register layout back to event vector
  function [NEV-1:0] word_to_ev;
    input [31:0] w;
    begin
      word_to_ev = {w[`TWE_IE_FINAL_TX_BIT], w[`TWE_IE_FINAL_RX_BIT],
                    w[`TWE_IE_TX_BEGUN_BIT], w[`TWE_IE_RX_BEGUN_BIT],
                    w[`TWE_IE_SUSPENDED_BIT], w[`TWE_IE_ERROR_BIT],
                    w[`TWE_IE_STOPPED_BIT]};
    end
  endfunction

  // Offset of each event flag
  function [AW-1:0] evt_off;
    input integer i;
    begin
      case (i)
        EV_STOPPED: evt_off = `TWE_EVT_STOPPED_OFF;
        EV_ERROR: evt_off = `TWE_EVT_ERROR_OFF;
        EV_SUSP: evt_off = `TWE_EVT_SUSPENDED_OFF;
        EV_RXB: evt_off = `TWE_EVT_RX_BEGUN_OFF;
        EV_TXB: evt_off = `TWE_EVT_TX_BEGUN_OFF;
        EV_FRX: evt_off = `TWE_EVT_FINAL_RX_OFF;
        default: evt_off = `TWE_EVT_FINAL_TX_OFF;
      endcase
    end
  endfunction

  // Offset of each channel route
  function [AW-1:0] pub_off;
    input integer i;
    begin
      case (i)
        EV_STOPPED: pub_off = `TWE_PUB_STOPPED_OFF;
        EV_ERROR: pub_off = `TWE_PUB_ERROR_OFF;
        EV_SUSP: pub_off = `TWE_PUB_SUSPENDED_OFF;
        EV_RXB: pub_off = `TWE_PUB_RX_BEGUN_OFF;
        EV_TXB: pub_off = `TWE_PUB_TX_BEGUN_OFF;
        EV_FRX: pub_off = `TWE_PUB_FINAL_RX_OFF;
        default: pub_off = `TWE_PUB_FINAL_TX_OFF;
      endcase
    end
  endfunction

  // Task-trigger write: strobe, matching offset, bit 0 set
  // Bus fields passed in, so every caller stays sensitive to them
  function task_hit;
    input wr;
    input [AW-1:0] addr;
    input wd0;
    input [AW-1:0] off;
    begin
      task_hit = wr & (addr == off) & wd0;
    end
  endfunction

  reg [NEV-1:0] flag_r;
  reg [NEV-1:0] flag_nxt;
  reg [NEV-1:0] ie_r;
  reg [NEV-1:0] ie_nxt;
  reg [5:0] links_r;
  reg halted_nxt;
  wire [NEV-1:0] ev_in;
  wire [31:0] pub_word [0:NEV-1];
  wire [NCH-1:0] pub_req [0:NEV-1];
  reg [NCH-1:0] chan_nxt;
  reg [31:0] rd_nxt;
  wire lk_tx_rx;
  wire lk_tx_pause;
  wire lk_tx_halt;
  wire lk_rx_tx;
  wire lk_rx_pause;
  wire lk_rx_halt;
  wire go_rx;
  wire go_tx;
  wire go_stop;
  wire go_susp;
  wire go_resume;
  integer i;
  integer j;
  integer k;

  // final rx byte event taken at byte boundary
  // final tx byte event taken at byte boundary
  assign ev_in = {evt_final_tx_byte, evt_final_rx_byte, evt_tx_begun, evt_rx_begun,
                  evt_suspended, evt_error, evt_stopped};

  // one route unit per event, same layout
  // six more routes share that layout
  genvar g;
  generate
    for (g = 0; g < NEV; g = g + 1) begin : g_pub
      twe_pub_unit #(
        .CH_W(CH_W),
        .NCH(NCH)
      ) u_pub (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cfg_we(reg_wr & (reg_addr == pub_off(g))),
        .cfg_wdata(reg_wdata),
        .evt_pulse(ev_in[g]),
        .cfg_word(pub_word[g]),
        .chan_req(pub_req[g])
      );
    end
  endgenerate

  // Merge requests; two events on one channel give one pulse
  always @* begin
    chan_nxt = {NCH{1'b0}};
    for (i = 0; i < NEV; i = i + 1) begin
      chan_nxt = chan_nxt | pub_req[i];
    end
  end

  // Link bits in use
  assign lk_tx_rx = links_r[0];
  assign lk_tx_pause = links_r[1];
  assign lk_tx_halt = links_r[2];
  assign lk_rx_tx = links_r[3];
  assign lk_rx_pause = links_r[4];
  assign lk_rx_halt = links_r[5];

  // register, channel and link task sources merge into one pulse; resume has no link source
  assign go_rx = task_hit(reg_wr, reg_addr, reg_wdata[0], `TWE_TASK_BEGIN_RX_OFF) | sub_begin_rx |
                 (evt_final_tx_byte & lk_tx_rx);
  assign go_tx = task_hit(reg_wr, reg_addr, reg_wdata[0], `TWE_TASK_BEGIN_TX_OFF) | sub_begin_tx |
                 (evt_final_rx_byte & lk_rx_tx);
  assign go_stop = task_hit(reg_wr, reg_addr, reg_wdata[0], `TWE_TASK_STOP_OFF) | sub_stop |
                   (evt_final_tx_byte & lk_tx_halt) | (evt_final_rx_byte & lk_rx_halt);
  assign go_susp = task_hit(reg_wr, reg_addr, reg_wdata[0], `TWE_TASK_SUSPEND_OFF) | sub_suspend |
                   (evt_final_tx_byte & lk_tx_pause) | (evt_final_rx_byte & lk_rx_pause);
  assign go_resume = task_hit(reg_wr, reg_addr, reg_wdata[0], `TWE_TASK_RESUME_OFF) | sub_resume;

  // Flags and enables, next values
  always @* begin
    flag_nxt = flag_r;
    ie_nxt = ie_r;
    for (j = 0; j < NEV; j = j + 1) begin
      if (reg_wr && reg_addr == evt_off(j)) begin
        flag_nxt[j] = reg_wdata[0];
      end
    end
    // hardware set wins over a software clear
    flag_nxt = flag_nxt | ev_in;
    // plain enable register writes all bits
    if (reg_wr && reg_addr == `TWE_IRQ_ENABLE_MASK_OFF) begin
      ie_nxt = word_to_ev(reg_wdata);
    end
    // ones set enables, zeros leave them
    // same enable bits for every event
    if (reg_wr && reg_addr == `TWE_IRQ_ENABLE_SET_OFF) begin
      ie_nxt = ie_r | word_to_ev(reg_wdata);
    end
    if (reg_wr && reg_addr == `TWE_IRQ_ENABLE_CLEAR_OFF) begin
      ie_nxt = ie_r & ~word_to_ev(reg_wdata);
    end
  end

  // halted from suspended event until resume
  always @* begin
    halted_nxt = traffic_halted;
    if (go_resume) begin
      halted_nxt = 1'b0;
    end
    if (evt_suspended) begin
      halted_nxt = 1'b1;
    end
  end

  // State registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= {NEV{1'b0}};
      ie_r <= {NEV{1'b0}};
      links_r <= 6'h00;
      traffic_halted <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      traffic_halted <= halted_nxt;
      // link bits clear at reset, set by write
      if (reg_wr && reg_addr == `TWE_LINKS_OFF) begin
        links_r <= {reg_wdata[`TWE_LNK_RX_HALT_BIT], reg_wdata[`TWE_LNK_RX_PAUSE_BIT],
                    reg_wdata[`TWE_LNK_RX_TX_BIT], reg_wdata[`TWE_LNK_TX_HALT_BIT],
                    reg_wdata[`TWE_LNK_TX_PAUSE_BIT], reg_wdata[`TWE_LNK_TX_RX_BIT]};
      end
    end
  end

  // Task and channel pulses, one cycle after their cause
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      begin_receive_task <= 1'b0;
      begin_transmit_task <= 1'b0;
      stop_task <= 1'b0;
      suspend_task <= 1'b0;
      resume_task <= 1'b0;
      chan_pulse <= {NCH{1'b0}};
    end else begin
      begin_receive_task <= go_rx;
      begin_transmit_task <= go_tx;
      // stop while halted is the caller's fault; passed on
      stop_task <= go_stop;
      suspend_task <= go_susp;
      resume_task <= go_resume;
      chan_pulse <= chan_nxt;
    end
  end

  // interrupt from flags that are also enabled
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_nxt & ie_nxt);
    end
  end

  // Read mux; unmapped and task offsets read zero
  always @* begin
    rd_nxt = `TWE_ZERO_RST;
    for (k = 0; k < NEV; k = k + 1) begin
      if (reg_addr == evt_off(k)) begin
        rd_nxt = {31'h00000000, flag_r[k]};
      end
      if (reg_addr == pub_off(k)) begin
        rd_nxt = pub_word[k];
      end
    end
    case (reg_addr)
      `TWE_LINKS_OFF: begin
        rd_nxt[`TWE_LNK_TX_RX_BIT] = links_r[0];
        rd_nxt[`TWE_LNK_TX_PAUSE_BIT] = links_r[1];
        rd_nxt[`TWE_LNK_TX_HALT_BIT] = links_r[2];
        rd_nxt[`TWE_LNK_RX_TX_BIT] = links_r[3];
        rd_nxt[`TWE_LNK_RX_PAUSE_BIT] = links_r[4];
        rd_nxt[`TWE_LNK_RX_HALT_BIT] = links_r[5];
      end
      `TWE_IRQ_ENABLE_MASK_OFF, `TWE_IRQ_ENABLE_SET_OFF, `TWE_IRQ_ENABLE_CLEAR_OFF: begin
        rd_nxt = ev_to_word(ie_r);
      end
      `TWE_STATUS_OFF: begin
        rd_nxt = {30'h00000000, irq, traffic_halted};
      end
      default: begin
        rd_nxt = rd_nxt;
      end
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `TWE_ZERO_RST;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= `TWE_ZERO_RST;
    end
  end

endmodule // twe_event_ctrl

// File: twe_regs.vh
`ifndef TWE_REGS_VH
`define TWE_REGS_VH

// Task trigger offsets
`define TWE_TASK_BEGIN_RX_OFF 12'h000
`define TWE_TASK_BEGIN_TX_OFF 12'h008
`define TWE_TASK_STOP_OFF 12'h014
`define TWE_TASK_SUSPEND_OFF 12'h01C
`define TWE_TASK_RESUME_OFF 12'h020

// Event flag offsets
`define TWE_EVT_STOPPED_OFF 12'h104
`define TWE_EVT_ERROR_OFF 12'h124
`define TWE_EVT_SUSPENDED_OFF 12'h148
`define TWE_EVT_RX_BEGUN_OFF 12'h14C
`define TWE_EVT_TX_BEGUN_OFF 12'h150
`define TWE_EVT_FINAL_RX_OFF 12'h15C
`define TWE_EVT_FINAL_TX_OFF 12'h160

// Channel route offsets
`define TWE_PUB_STOPPED_OFF 12'h184
`define TWE_PUB_ERROR_OFF 12'h1A4
`define TWE_PUB_SUSPENDED_OFF 12'h1C8
`define TWE_PUB_RX_BEGUN_OFF 12'h1CC
`define TWE_PUB_TX_BEGUN_OFF 12'h1D0
`define TWE_PUB_FINAL_RX_OFF 12'h1DC
`define TWE_PUB_FINAL_TX_OFF 12'h1E0

// Link, interrupt enable and status offsets
`define TWE_LINKS_OFF 12'h200
`define TWE_IRQ_ENABLE_MASK_OFF 12'h300
`define TWE_IRQ_ENABLE_SET_OFF 12'h304
`define TWE_IRQ_ENABLE_CLEAR_OFF 12'h308
`define TWE_STATUS_OFF 12'h400

// Channel route fields
`define TWE_PUB_CHANNEL_INDEX_LSB 0
`define TWE_PUB_CHANNEL_INDEX_W 4
`define TWE_PUB_EN_BIT 31

// Event-to-task link bit positions
`define TWE_LNK_TX_RX_BIT 7
`define TWE_LNK_TX_PAUSE_BIT 8
`define TWE_LNK_TX_HALT_BIT 9
`define TWE_LNK_RX_TX_BIT 10
`define TWE_LNK_RX_PAUSE_BIT 11
`define TWE_LNK_RX_HALT_BIT 12

// Interrupt enable bit positions per event
`define TWE_IE_STOPPED_BIT 1
`define TWE_IE_ERROR_BIT 9
`define TWE_IE_SUSPENDED_BIT 18
`define TWE_IE_RX_BEGUN_BIT 19
`define TWE_IE_TX_BEGUN_BIT 20
`define TWE_IE_FINAL_RX_BIT 23
`define TWE_IE_FINAL_TX_BIT 24

// Reset values
`define TWE_ZERO_RST 32'h00000000

`endif

// File: twe_pub_unit.v
`timescale 1ns/1ps
`include "twe_regs.vh"

module twe_pub_unit #(
  parameter CH_W = 4,
  parameter NCH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Configuration write
  input wire cfg_we,
  input wire [31:0] cfg_wdata,
  // Event in
  input wire evt_pulse,
  // Configuration view and channel request
  output wire [31:0] cfg_word,
  output wire [NCH-1:0] chan_req
);

  reg [CH_W-1:0] channel_index_r;
  reg en_r;

  // Channel index and enable, both clear at reset
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      channel_index_r <= {CH_W{1'b0}};
      en_r <= 1'b0;
    end else if (cfg_we) begin
      channel_index_r <= cfg_wdata[`TWE_PUB_CHANNEL_INDEX_LSB +: CH_W];
      en_r <= cfg_wdata[`TWE_PUB_EN_BIT];
    end
  end

  // Unused bits read back as zero
  assign cfg_word = {en_r, {(31-CH_W){1'b0}}, channel_index_r};

  // One-hot request on the chosen channel only while enabled
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      assign chan_req[g] = evt_pulse & en_r & (channel_index_r == g);
    end
  endgenerate

endmodule // twe_pub_unit

// File: twe_ctrl_chk_asserts.sv
`timescale 1ns/1ps
module twe_ctrl_chk #(
  parameter AW = 12
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register port
  input wire [AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Engine events and subscribed task
  input wire evt_suspended,
  input wire evt_final_rx_byte,
  input wire evt_final_tx_byte,
  input wire sub_begin_rx,
  // Task and status outputs
  input wire begin_receive_task,
  input wire begin_transmit_task,
  input wire stop_task,
  input wire suspend_task,
  input wire traffic_halted,
  input wire irq
);
  reg [31:0] links_r;
  reg [31:0] ie_r;
  // Shadow of link and enable words, so no check peeks inside the block
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      links_r <= 32'h0;
      ie_r <= 32'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        12'h200: links_r <= reg_wdata;
        12'h300: ie_r <= reg_wdata;
        12'h304: ie_r <= ie_r | reg_wdata;
        12'h308: ie_r <= ie_r & ~reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_tx_to_rx: assert property (evt_final_tx_byte && links_r[7] |=> begin_receive_task)
    else $error("tx end link missed receive start");
  a_tx_to_pause: assert property (evt_final_tx_byte && links_r[8] |=> suspend_task)
    else $error("tx end link missed suspend");
  a_tx_to_halt: assert property (evt_final_tx_byte && links_r[9] |-> ##1 stop_task)
    else $error("tx end link missed stop");
  a_rx_to_halt: assert property (evt_final_rx_byte && links_r[12] |=> stop_task)
    else $error("rx end link missed stop");
  a_rx_to_tx: assert property (evt_final_rx_byte && links_r[10] |=> begin_transmit_task)
    else $error("rx end link missed transmit start");
  a_rx_to_pause: assert property (evt_final_rx_byte && links_r[11] |=> suspend_task)
    else $error("rx end link missed suspend");
  a_halt_set: assert property (evt_suspended |=> traffic_halted)
    else $error("halt not set after suspended event");
  a_sub_rx_task: assert property (sub_begin_rx |=> begin_receive_task)
    else $error("subscribed receive start lost");
  a_irq_masked: assert property (ie_r == 32'h0 |-> !irq)
    else $error("interrupt with all enables off");
  c_link: cover property (evt_final_tx_byte && links_r[7]);
  c_irq: cover property ($rose(irq));
  c_halt: cover property ($rose(traffic_halted));
endmodule // twe_ctrl_chk

bind twe_event_ctrl twe_ctrl_chk #(.AW(AW)) twe_ctrl_chk_i (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .evt_suspended, .evt_final_rx_byte, .evt_final_tx_byte, .sub_begin_rx,
  .begin_receive_task, .begin_transmit_task, .stop_task, .suspend_task, .traffic_halted, .irq);

// File: twe_chan_model.sv
`timescale 1ns/1ps
module twe_chan_model (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Channel lines and engine state
  input wire [15:0] chan_pulse,
  input wire traffic_halted,
  // Subscriptions: enable and channel per task, slow answer
  input wire [4:0] sub_en,
  input wire [19:0] sub_ch,
  input wire slow,
  // Task pulses: rx, tx, stop, suspend, resume
  output reg [4:0] sub_task
);
  reg [4:0] hit_nxt;
  reg [4:0] hold_r;
  integer k;
  // Match each subscription against its channel
  always @* begin
    for (k = 0; k < 5; k = k + 1) begin
      hit_nxt[k] = sub_en[k] & chan_pulse[sub_ch[4*k +: 4]];
    end
    if (traffic_halted) begin
      hit_nxt[2] = 1'b0;
    end
  end
  // Slow mode delays the answer one more cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= 5'h0;
      sub_task <= 5'h0;
    end else begin
      hold_r <= hit_nxt;
      sub_task <= slow ? hold_r : hit_nxt;
    end
  end
endmodule // twe_chan_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg [11:0] reg_addr = 12'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [6:0] evt = 7'h0;
  reg [4:0] sub_en = 5'h0;
  reg [19:0] sub_ch = 20'h0;
  reg slow = 1'b0;
  wire [31:0] reg_rdata;
  wire [4:0] tsk;
  wire [4:0] sub_task;
  wire [15:0] chan_pulse;
  wire traffic_halted;
  wire irq;
  integer err_count = 0;
  integer samples_checked = 0;
  integer i;
  // Flag offsets then route offsets, by event order
  localparam [167:0] OFFS = {12'h1E0, 12'h1DC, 12'h1D0, 12'h1CC, 12'h1C8, 12'h1A4, 12'h184,
    12'h160, 12'h15C, 12'h150, 12'h14C, 12'h148, 12'h124, 12'h104};
  // Expected task pulses per link bit, {resume,suspend,stop,tx,rx}
  localparam [29:0] LNK_EXP = {5'h04, 5'h08, 5'h02, 5'h04, 5'h08, 5'h01};
  // Task trigger offsets, {resume,suspend,stop,tx,rx}
  localparam [59:0] TSK_OFFS = {12'h020, 12'h01C, 12'h014, 12'h008, 12'h000};
  always #2.5 ref_clk = ~ref_clk;
  twe_event_ctrl twe_event_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt_stopped(evt[0]), .evt_error(evt[1]), .evt_suspended(evt[2]), .evt_rx_begun(evt[3]),
    .evt_tx_begun(evt[4]), .evt_final_rx_byte(evt[5]), .evt_final_tx_byte(evt[6]),
    .sub_begin_rx(sub_task[0]), .sub_begin_tx(sub_task[1]), .sub_stop(sub_task[2]),
    .sub_suspend(sub_task[3]), .sub_resume(sub_task[4]), .begin_receive_task(tsk[0]),
    .begin_transmit_task(tsk[1]), .stop_task(tsk[2]), .suspend_task(tsk[3]), .resume_task(tsk[4]),
    .traffic_halted(traffic_halted), .irq(irq), .chan_pulse(chan_pulse));
  twe_chan_model twe_chan_model_i (.ref_clk(ref_clk), .nrst(nrst), .chan_pulse(chan_pulse),
    .traffic_halted(traffic_halted), .sub_en(sub_en), .sub_ch(sub_ch), .slow(slow), .sub_task(sub_task));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  // Event high for one cycle; returns where its results stand
  task pulse(input [6:0] ev);
    begin
      @(posedge ref_clk);
      evt <= ev;
      @(posedge ref_clk);
      evt <= 7'h0;
      #1;
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 14; i = i + 1) rd(OFFS[12*i +: 12], 32'h0);
      rd(12'h200, 32'h0);
      rd(12'h300, 32'h0);
      rd(12'h0FC, 32'h0);
    end
  endtask
  task t_flags;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        pulse(7'h1 << i);
        chk({16'h0, chan_pulse}, 32'h0);
        rd(OFFS[12*i +: 12], 32'h1);
        wr(OFFS[12*i +: 12], 32'h0);
        rd(OFFS[12*i +: 12], 32'h0);
      end
      wr(12'h020, 32'h1);
    end
  endtask
  task t_routes;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        wr(OFFS[12*(i+7) +: 12], 32'h80000000 | ((i*5) % 16));
        pulse(7'h1 << i);
        chk({16'h0, chan_pulse}, 32'h1 << ((i*5) % 16));
        rd(OFFS[12*(i+7) +: 12], 32'h80000000 | ((i*5) % 16));
        wr(OFFS[12*i +: 12], 32'h0);
      end
      wr(12'h184, 32'h7FFFFFFF);
      rd(12'h184, 32'h0000000F);
      pulse(7'h01);
      chk({16'h0, chan_pulse}, 32'h0);
      wr(12'h104, 32'h0);
      wr(12'h020, 32'h1);
    end
  endtask
  task t_links;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        wr(12'h200, 32'h80 << i);
        pulse(i < 3 ? 7'h40 : 7'h20);
        chk({27'h0, tsk}, {27'h0, LNK_EXP[5*i +: 5]});
      end
      wr(12'h200, 32'h0);
      pulse(7'h60);
      chk({27'h0, tsk}, 32'h0);
      wr(12'h15C, 32'h0);
      wr(12'h160, 32'h0);
    end
  endtask
  task t_irq;
    begin
      wr(12'h304, 32'h2);
      wr(12'h304, 32'h0);
      rd(12'h300, 32'h2);
      wr(12'h304, 32'hFFFFFFFF);
      rd(12'h304, 32'h019C0202);
      wr(12'h308, 32'h01000000);
      rd(12'h308, 32'h009C0202);
      pulse(7'h40);
      chk({31'h0, irq}, 32'h0);
      pulse(7'h02);
      chk({31'h0, irq}, 32'h1);
      rd(12'h400, 32'h2);
      wr(12'h124, 32'h0);
      wr(12'h160, 32'h0);
      @(posedge ref_clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(12'h300, 32'h0);
      rd(12'h300, 32'h0);
    end
  endtask
  task t_halt;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        wr(TSK_OFFS[12*i +: 12], 32'h1);
        #1;
        chk({27'h0, tsk}, 32'h1 << i);
      end
      wr(12'h000, 32'h0);
      #1;
      chk({27'h0, tsk}, 32'h0);
      sub_en <= 5'h04;
      sub_ch <= 20'h00A00;
      pulse(7'h04);
      chk({31'h0, traffic_halted}, 32'h1);
      rd(12'h400, 32'h1);
      repeat (4) begin
        @(posedge ref_clk);
        #1;
        chk({31'h0, tsk[2]}, 32'h0);
      end
      wr(12'h020, 32'h1);
      #1;
      chk({31'h0, tsk[4]}, 32'h1);
      @(posedge ref_clk);
      #1;
      chk({31'h0, traffic_halted}, 32'h0);
      wr(12'h148, 32'h0);
      sub_en <= 5'h01;
      sub_ch <= 20'h0000E;
      repeat (2) begin
        pulse(7'h40);
        for (i = 0; i < 8 && tsk[0] !== 1'b1; i = i + 1) begin
          @(posedge ref_clk);
          #1;
        end
        chk({31'h0, tsk[0]}, 32'h1);
        slow <= 1'b1;
      end
      wr(12'h160, 32'h0);
    end
  endtask
  task end_of_test;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_flags;
    t_routes;
    t_links;
    t_irq;
    t_halt;
    end_of_test;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    err_count = err_count + 1;
    end_of_test;
  end
endmodule // tb_top
